/* File: common/pfm_pkg.sv */
package pfm_pkg;
    // ************************************************************
    // register map (avalon word offsets, byte addresses)
    // ************************************************************
    localparam logic [3:0] REG_SEL = 4'h0; // group select bits
    localparam logic [3:0] REG_OUT = 4'h4; // gpio2 output data
    localparam logic [3:0] REG_DIR = 4'h8; // gpio2 direction, 1 = output
    localparam logic [3:0] REG_IN = 4'hc; // gpio2 pad levels, read only

    // ************************************************************
    // select register field positions
    // ************************************************************
    localparam int SEL_HOST = 0;
    localparam int SEL_ADC = 1;
    localparam int SEL_I2S_GPIO = 2;
    localparam int SEL_VSYNC = 3;
    localparam int SEL_DEN = 4;
    localparam int SEL_ADCCLK = 5;
    localparam int SEL_CARD = 6;
    localparam int SEL_IQ = 7;
    localparam int SEL_HCLKIN = 8;
    localparam int SEL_LCD_MODE = 9; // three bits, 11:9
    localparam int SEL_W = 12;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [SEL_W-1:0] SEL_RST = 12'h000;
    localparam logic [31:0] OUT_RST = 32'h0000_0000;
    localparam logic [31:0] DIR_RST = 32'h0000_0000;

    // ************************************************************
    // pull codes and per-pad gpio default pulls
    // ************************************************************
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_UP = 2'h1;
    localparam logic [1:0] PULL_DOWN = 2'h2;
    localparam int BANK2_PU_LAST = 15;

    // panel modes
    typedef enum logic [2:0] {
        PFM_MCU18 = 3'h0,
        PFM_MCU16 = 3'h1,
        PFM_RGB24 = 3'h3,
        PFM_RGB18 = 3'h2,
        PFM_RGB8 = 3'h6,
        PFM_ESV = 3'h7
    } pfm_lcd_mode_t;

    // pad control bundle
    typedef struct packed {
        logic [31:0] out;
        logic [31:0] oe;
        logic [63:0] pull;
    } pfm_pad_ctl_t;

    // host port signals toward the host-port logic
    typedef struct packed {
        logic [7:0] d_in;
        logic [1:0] addr;
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } pfm_hport_in_t;

    typedef struct packed {
        logic [7:0] d_out;
        logic [7:0] d_oe;
        logic irq;
    } pfm_hport_out_t;
endpackage : pfm_pkg

/* File: verilog/pfm_mux.sv */
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - host mode: pads 0-7 carry bidirectional host data, pulled up
// - host mode: pads 8,9 are input host address bits 0,1
// - host mode: pad 10 inputs host active-low chip select
// - host mode: pad 11 inputs host active-low read strobe
// - host mode: pad 12 inputs host active-low write strobe
// - host mode: pad 13 drives interrupt request out to host
// - adc mode: pads 14-23 input ten Q-path adc bits, lsb pad 14
// - gpio pulls: up on pads 0-15, down on pads 16-31
// - pad 24 offers pulled-down clock input for positioning receiver
// - pad 24 offers adc sampling clock output
// - pad 25 outputs lcd vertical sync when selected, else gpio
// - pad 26 outputs lcd data enable when selected, else gpio
// - audio: pads 27-31 sdi in, sdo, bclk out, ws and sclk bidir
// - card: h0-h5 cmd, data, clock; h6 iq marker, h7 adc clock in
// - direction honoured: bidir per-pad enable, outputs drive, inputs off
// - lcd data bus mapped per panel mode
// - host select: clear gpio, set host port on pads 0-13
// - adc select: clear gpio, set adc data on pads 14-23
// - audio select inverted: clear audio, set gpio
// - gpio pads reset as inputs
module pfm_mux (
    input wire logic clock_i,
    input wire logic reset_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // second bank pads
    input wire logic [31:0] pad2_in_i,
    output pfm_pkg::pfm_pad_ctl_t pad2_ctl_o,
    // h group pads 0..7
    input wire logic [7:0] padh_in_i,
    output pfm_pkg::pfm_pad_ctl_t padh_ctl_o,
    input wire logic [7:0] gpioh_out_i,
    input wire logic [7:0] gpioh_oe_i,
    output logic [7:0] gpioh_in_o,
    // host port
    output pfm_pkg::pfm_hport_in_t hport_in_o,
    input wire pfm_pkg::pfm_hport_out_t hport_out_i,
    // adc and clocks
    output logic [9:0] adc_q_data_o,
    input wire logic adc_clk_out_i,
    output logic posn_clk_o,
    output logic adc_clk_in_o,
    output logic external_iq_marker_o,
    // lcd
    input wire logic lcd_vsync_i,
    input wire logic lcd_den_i,
    input wire logic [23:0] lcd_bus_i,
    output logic [23:0] lcd_pins_o,
    // audio
    output logic i2s_sdi_o,
    input wire logic i2s_sdo_i,
    input wire logic i2s_bclk_i,
    input wire logic [1:0] i2s_bidir_out_i,
    input wire logic [1:0] i2s_bidir_oe_i,
    output logic [1:0] i2s_bidir_in_o,
    // card port 0
    input wire logic card0_command_line_out_i,
    input wire logic card0_command_line_oe_i,
    output logic card0_command_line_in_o,
    input wire logic [3:0] card0_data_out_i,
    input wire logic [3:0] card0_data_oe_i,
    output logic [3:0] card0_data_in_o,
    input wire logic card0_clk_out_i
);
    import pfm_pkg::*;

    // ************************************************************
    // register file
    // ************************************************************
    logic [SEL_W-1:0] sel;
    logic [31:0] gout;
    logic [31:0] gdir;
    logic [SEL_W-1:0] next_sel;
    logic [31:0] next_gout;
    logic [31:0] next_gdir;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [31:0] pad_view;
    logic rd_done;
    logic next_rd_done;

    // byte-lane merge of a write into a held word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // writes finish at once; a read waits one cycle so its word already stands
    // in the flop when waitrequest drops, keeping readdata registered
    assign avs_waitrequest_o = avs_read_i && !rd_done;
    assign avs_readdata_o = rdata;

    // next register values and read word
    always_comb begin
        logic [31:0] w;
        w = 32'h0000_0000;
        next_sel = sel;
        next_gout = gout;
        next_gdir = gdir;
        next_rdata = rdata;
        next_rd_done = avs_read_i && !rd_done;
        if (avs_write_i) begin
            if (avs_address_i == REG_SEL) begin
                w = merge({20'h00000, sel}, avs_writedata_i, avs_byteenable_i);
                next_sel = w[SEL_W-1:0];
            end else if (avs_address_i == REG_OUT) begin
                next_gout = merge(gout, avs_writedata_i, avs_byteenable_i);
            end else if (avs_address_i == REG_DIR) begin
                next_gdir = merge(gdir, avs_writedata_i, avs_byteenable_i);
            end
        end
        if (avs_read_i) begin
            if (avs_address_i == REG_SEL) begin
                next_rdata = {20'h00000, sel};
            end else if (avs_address_i == REG_OUT) begin
                next_rdata = gout;
            end else if (avs_address_i == REG_DIR) begin
                next_rdata = gdir;
            end else if (avs_address_i == REG_IN) begin
                next_rdata = pad_view;
            end else begin
                next_rdata = 32'h0000_0000; // unmapped reads zero
            end
        end
    end

    // register stage; directions clear so every gpio starts as input
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sel <= SEL_RST;
            gout <= OUT_RST;
            gdir <= DIR_RST;
            rdata <= 32'h0000_0000;
            rd_done <= 1'b0;
        end else begin
            sel <= next_sel;
            gout <= next_gout;
            gdir <= next_gdir;
            rdata <= next_rdata;
            rd_done <= next_rd_done;
        end
    end

    // ************************************************************
    // second bank pad routing (all combinational)
    // ************************************************************
    logic host_on;
    logic adc_on;
    logic i2s_on;
    assign host_on = sel[SEL_HOST];
    assign adc_on = sel[SEL_ADC];
    assign i2s_on = !sel[SEL_I2S_GPIO];
    assign pad_view = pad2_in_i;

    // pad 24 function picks: adc clock out wins over gpio
    logic pad24_clk_out;
    assign pad24_clk_out = sel[SEL_ADCCLK];

    // default gpio view, then peripheral overrides per group
    always_comb begin
        pad2_ctl_o.out = gout;
        pad2_ctl_o.oe = gdir;
        for (int p = 0; p < 32; p++) begin
            pad2_ctl_o.pull[p*2 +: 2] = (p <= BANK2_PU_LAST) ? PULL_UP : PULL_DOWN;
        end
        if (host_on) begin
            // gpio drive suppressed, peripheral takes over
            pad2_ctl_o.out[7:0] = hport_out_i.d_out;
            pad2_ctl_o.oe[7:0] = hport_out_i.d_oe;
            pad2_ctl_o.oe[12:8] = 5'h00;
            pad2_ctl_o.out[12:8] = 5'h00;
            pad2_ctl_o.out[13] = hport_out_i.irq;
            pad2_ctl_o.oe[13] = 1'b1;
        end
        if (adc_on) begin
            pad2_ctl_o.out[23:14] = 10'h000;
            pad2_ctl_o.oe[23:14] = 10'h000;
        end
        if (pad24_clk_out) begin
            pad2_ctl_o.out[24] = adc_clk_out_i;
            pad2_ctl_o.oe[24] = 1'b1;
        end
        if (sel[SEL_VSYNC]) begin
            pad2_ctl_o.out[25] = lcd_vsync_i;
            pad2_ctl_o.oe[25] = 1'b1;
        end
        if (sel[SEL_DEN]) begin
            pad2_ctl_o.out[26] = lcd_den_i;
            pad2_ctl_o.oe[26] = 1'b1;
        end
        if (i2s_on) begin
            pad2_ctl_o.out[27] = 1'b0;
            pad2_ctl_o.oe[27] = 1'b0;
            pad2_ctl_o.out[28] = i2s_sdo_i;
            pad2_ctl_o.oe[28] = 1'b1;
            pad2_ctl_o.out[29] = i2s_bclk_i;
            pad2_ctl_o.oe[29] = 1'b1;
            pad2_ctl_o.out[31:30] = i2s_bidir_out_i;
            pad2_ctl_o.oe[31:30] = i2s_bidir_oe_i;
        end
    end

    // peripheral inputs see the pad only while their group is selected; the positioning clock whenever pad 24 is not driving the adc clock
    always_comb begin
        hport_in_o.d_in = host_on ? pad2_in_i[7:0] : 8'h00;
        hport_in_o.addr = host_on ? pad2_in_i[9:8] : 2'h0;
        // strobes idle high when not routed, so the host port stays quiet
        hport_in_o.cs_n = host_on ? pad2_in_i[10] : 1'b1;
        hport_in_o.rd_n = host_on ? pad2_in_i[11] : 1'b1;
        hport_in_o.wr_n = host_on ? pad2_in_i[12] : 1'b1;
        adc_q_data_o = adc_on ? pad2_in_i[23:14] : 10'h000;
        // clock input for positioning receiver listens unless pad 24 drives the adc clock; pulled down
        posn_clk_o = pad24_clk_out ? 1'b0 : pad2_in_i[24];
        i2s_sdi_o = i2s_on ? pad2_in_i[27] : 1'b0;
        i2s_bidir_in_o = i2s_on ? pad2_in_i[31:30] : 2'h0;
    end

    // ************************************************************
    // h group card port and clock inputs
    // ************************************************************
    logic card_on;
    assign card_on = sel[SEL_CARD];
    assign gpioh_in_o = padh_in_i;

    // h pads: gpio controller drives unless the card, iq marker or clock input function owns the pad
    always_comb begin
        padh_ctl_o.out = {24'h000000, gpioh_out_i};
        padh_ctl_o.oe = {24'h000000, gpioh_oe_i};
        padh_ctl_o.pull = '0;
        for (int p = 0; p < 8; p++) begin
            padh_ctl_o.pull[p*2 +: 2] = PULL_DOWN;
        end
        if (card_on) begin
            padh_ctl_o.out[0] = card0_command_line_out_i;
            padh_ctl_o.oe[0] = card0_command_line_oe_i;
            padh_ctl_o.out[4:1] = card0_data_out_i;
            padh_ctl_o.oe[4:1] = card0_data_oe_i;
            padh_ctl_o.out[5] = card0_clk_out_i;
            padh_ctl_o.oe[5] = 1'b1;
        end
        if (sel[SEL_IQ]) begin
            padh_ctl_o.out[6] = 1'b0;
            padh_ctl_o.oe[6] = 1'b0;
        end
        if (sel[SEL_HCLKIN]) begin
            padh_ctl_o.out[7] = 1'b0;
            padh_ctl_o.oe[7] = 1'b0;
        end
    end

    // card inputs idle high when off so the controller sees no start bit
    always_comb begin
        card0_command_line_in_o = card_on ? padh_in_i[0] : 1'b1;
        card0_data_in_o = card_on ? padh_in_i[4:1] : 4'hf;
        external_iq_marker_o = sel[SEL_IQ] ? padh_in_i[6] : 1'b0;
        adc_clk_in_o = sel[SEL_HCLKIN] ? padh_in_i[7] : 1'b0;
    end

    // ************************************************************
    // lcd data bus mapping per panel mode
    // ************************************************************
    pfm_lcd_mode_t lcd_mode;
    assign lcd_mode = pfm_lcd_mode_t'(sel[SEL_LCD_MODE +: 3]);

    // lcd_bus_i packs the controller's colours as r[7:0] g[15:8] b[23:16]
    always_comb begin
        lcd_pins_o = 24'h000000;
        case (lcd_mode)
            PFM_MCU18: lcd_pins_o[17:0] = lcd_bus_i[17:0];
            PFM_MCU16: lcd_pins_o[15:0] = lcd_bus_i[15:0];
            PFM_RGB24: lcd_pins_o = lcd_bus_i; // R0 D0, G0 D8, B0 D16
            PFM_RGB18: begin
                lcd_pins_o[5:0] = lcd_bus_i[5:0];
                lcd_pins_o[11:6] = lcd_bus_i[13:8]; // g0 on d6
                lcd_pins_o[17:12] = lcd_bus_i[21:16]; // b0 on d12
            end
            PFM_RGB8: lcd_pins_o[7:0] = lcd_bus_i[7:0];
            PFM_ESV: lcd_pins_o[7:0] = lcd_bus_i[7:0];
            default: lcd_pins_o = 24'h000000;
        endcase
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_gpio_reset_input: assert property (@(posedge clock_i)
        reset_i |=> (gdir == 32'h0000_0000))
        else $error("gpio direction not cleared by reset");
    a_host_irq_drive: assert property (@(posedge clock_i) disable iff (reset_i)
        host_on |-> (pad2_ctl_o.oe[13] && pad2_ctl_o.out[13] == hport_out_i.irq))
        else $error("host irq pad not driven");
    a_host_in_off: assert property (@(posedge clock_i) disable iff (reset_i)
        host_on |-> (pad2_ctl_o.oe[12:8] == 5'h00 && hport_in_o.cs_n == pad2_in_i[10]))
        else $error("host input pad driven or not routed");
    a_adc_route: assert property (@(posedge clock_i) disable iff (reset_i)
        adc_on |-> (adc_q_data_o == pad2_in_i[23:14] && pad2_ctl_o.oe[23:14] == 10'h000))
        else $error("adc data not routed");
    a_i2s_inverted: assert property (@(posedge clock_i) disable iff (reset_i)
        sel[SEL_I2S_GPIO] |-> (pad2_ctl_o.oe[31:27] == gdir[31:27]))
        else $error("audio pads not gpio when select set");
    a_pull_split: assert property (@(posedge clock_i) disable iff (reset_i)
        pad2_ctl_o.pull[31:30] == PULL_UP && pad2_ctl_o.pull[33:32] == PULL_DOWN)
        else $error("bank pull split wrong");
    a_sel_write_take: assert property (@(posedge clock_i) disable iff (reset_i)
        (avs_write_i && avs_address_i == REG_SEL && avs_byteenable_i == 4'hf)
        |=> (sel == $past(avs_writedata_i[SEL_W-1:0])))
        else $error("select write not taken");
    a_card_clk: assert property (@(posedge clock_i) disable iff (reset_i)
        card_on |-> (padh_ctl_o.oe[5] && padh_ctl_o.out[5] == card0_clk_out_i))
        else $error("card clock not driven");
    a_lcd_rgb18: assert property (@(posedge clock_i) disable iff (reset_i)
        lcd_mode == PFM_RGB18
        |-> (lcd_pins_o[6] == lcd_bus_i[8] && lcd_pins_o[12] == lcd_bus_i[16]))
        else $error("rgb18 mapping wrong");
    a_read_one_wait: assert property (@(posedge clock_i) disable iff (reset_i)
        (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("read held in wait too long");
    a_host_idle_strobes: assert property (@(posedge clock_i) disable iff (reset_i)
        !host_on |-> (hport_in_o.cs_n && hport_in_o.rd_n && hport_in_o.wr_n))
        else $error("host strobes active while host group off");
    a_card_off_gpio: assert property (@(posedge clock_i) disable iff (reset_i)
        !card_on |-> (padh_ctl_o.oe[5:0] == gpioh_oe_i[5:0]))
        else $error("card pads not gpio when card off");
    a_posn_clk_in: assert property (@(posedge clock_i) disable iff (reset_i)
        !pad24_clk_out
        |-> (posn_clk_o == pad2_in_i[24] && pad2_ctl_o.pull[49:48] == PULL_DOWN))
        else $error("positioning clock input not routed");
endmodule : pfm_mux

/* File: bench/pfm_pad_model.sv */
`timescale 1ns/1ps
module pfm_pad_model (
    input wire pfm_pkg::pfm_pad_ctl_t ctl_i,
    input wire logic [31:0] ext_drv_i,
    input wire logic [31:0] ext_en_i,
    output logic [31:0] level_o
);
    import pfm_pkg::*;
    // ****************************************
    // pad wire resolution
    // ****************************************
    // chip drive wins over the far side; an undriven pad sits at its pull,
    // and with no pull it shows the inverse of the far value so it never looks held
    always_comb begin
        for (int p = 0; p < 32; p++) begin
            if (ctl_i.oe[p]) begin
                level_o[p] = ctl_i.out[p];
            end else if (ext_en_i[p]) begin
                level_o[p] = ext_drv_i[p];
            end else if (ctl_i.pull[2*p +: 2] == PULL_UP) begin
                level_o[p] = 1'b1;
            end else if (ctl_i.pull[2*p +: 2] == PULL_DOWN) begin
                level_o[p] = 1'b0;
            end else begin
                level_o[p] = ~ext_drv_i[p];
            end
        end
    end
endmodule : pfm_pad_model

/* File: bench/test_pfm_mux.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_pfm_mux;
    import pfm_pkg::*;
    logic clock_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, pad2_in_i, ext2, en2, lvlh, eo;
    pfm_pad_ctl_t pad2_ctl_o, padh_ctl_o;
    logic [7:0] padh_in_i, gpioh_out_i, gpioh_oe_i, gpioh_in_o, exth;
    pfm_hport_in_t hport_in_o;
    pfm_hport_out_t hport_out_i;
    logic [9:0] adc_q_data_o;
    logic adc_clk_out_i, posn_clk_o, adc_clk_in_o, external_iq_marker_o;
    logic lcd_vsync_i, lcd_den_i, i2s_sdi_o, i2s_sdo_i, i2s_bclk_i;
    logic [23:0] lcd_bus_i, lcd_pins_o;
    logic [1:0] i2s_bidir_out_i, i2s_bidir_oe_i, i2s_bidir_in_o;
    logic card0_command_line_out_i, card0_command_line_oe_i, card0_command_line_in_o;
    logic card0_clk_out_i;
    logic [3:0] card0_data_out_i, card0_data_oe_i, card0_data_in_o;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h4};

    pfm_mux i_pfm_mux (
        .clock_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pad2_in_i, .pad2_ctl_o,
        .padh_in_i, .padh_ctl_o, .gpioh_out_i, .gpioh_oe_i, .gpioh_in_o, .hport_in_o,
        .hport_out_i, .adc_q_data_o, .adc_clk_out_i, .posn_clk_o, .adc_clk_in_o,
        .external_iq_marker_o, .lcd_vsync_i, .lcd_den_i, .lcd_bus_i, .lcd_pins_o, .i2s_sdi_o,
        .i2s_sdo_i, .i2s_bclk_i, .i2s_bidir_out_i, .i2s_bidir_oe_i, .i2s_bidir_in_o,
        .card0_command_line_out_i, .card0_command_line_oe_i, .card0_command_line_in_o,
        .card0_data_out_i, .card0_data_oe_i, .card0_data_in_o, .card0_clk_out_i
    );
    pfm_pad_model i_bank2_pads (.ctl_i(pad2_ctl_o), .ext_drv_i(ext2), .ext_en_i(en2),
        .level_o(pad2_in_i));
    pfm_pad_model i_h_pads (.ctl_i(padh_ctl_o), .ext_drv_i({24'h0, exth}),
        .ext_en_i(32'hffff_ffff), .level_o(lvlh));
    assign padh_in_i = lvlh[7:0];

    // ****************************************
    // clock, watchdog, verdict
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // the sequence needs under a hundred cycles; the ceiling leaves ample margin
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // avalon master and expectations
    // ****************************************
    // request held until waitrequest is seen low; read data taken at that edge,
    // then released; only the watchdog ends a wait that never finishes
    task automatic av_req(input logic rd, input logic [3:0] a, input logic [31:0] wd,
                          output logic [31:0] rdat);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_read_i <= rd;
        avs_write_i <= ~rd;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0) begin
            @(posedge clock_i);
        end
        rdat = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : av_req
    task automatic wr(input logic [3:0] a, input logic [31:0] wd);
        logic [31:0] unused;
        av_req(1'b0, a, wd, unused);
    endtask : wr
    // read data stands at the edge that sees waitrequest low
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] got;
        av_req(1'b1, a, 32'h0, got);
        `CHK(got, exp)
    endtask : rd_chk
    function automatic logic [23:0] lcd_exp(input logic [2:0] m, input logic [23:0] b);
        case (m)
            3'h0: return b & 24'h03_ffff;
            3'h1: return b & 24'h00_ffff;
            3'h3: return b;
            3'h2: return {6'h0, b[21:16], b[13:8], b[5:0]};
            3'h6, 3'h7: return b & 24'h00_00ff;
            default: return 24'h0;
        endcase
    endfunction : lcd_exp

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, gpioh_out_i, gpioh_oe_i} = '0;
        {hport_out_i, adc_clk_out_i, lcd_vsync_i, lcd_den_i, i2s_sdo_i, i2s_bclk_i} = '0;
        {i2s_bidir_out_i, i2s_bidir_oe_i, card0_command_line_out_i, card0_command_line_oe_i} = '0;
        {card0_data_out_i, card0_data_oe_i, card0_clk_out_i} = '0;
        avs_byteenable_i = 4'hf;
        reset_i = 1'b1;
        ext2 = 32'h5a3c_96e1;
        en2 = 32'hffff_ffff;
        exth = 8'hf4;
        lcd_bus_i = 24'hc3_5a96;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        // reset state: only the audio outputs drive
        rd_chk(REG_SEL, 32'h0);
        rd_chk(REG_OUT, 32'h0);
        rd_chk(REG_DIR, 32'h0);
        rd_chk(4'h2, 32'h0);
        `CHK(pad2_ctl_o.oe, 32'h3000_0000)
        `CHK(padh_ctl_o.oe, 32'h0)
        // plain gpio drive, default pulls, pad readback
        wr(REG_SEL, 32'h4);
        wr(REG_OUT, 32'h0f0f_3cc3);
        wr(REG_DIR, 32'hffff_ffff);
        #1;
        `CHK(pad2_ctl_o.out, 32'h0f0f_3cc3)
        `CHK(pad2_ctl_o.oe, 32'hffff_ffff)
        `CHK(pad2_ctl_o.pull, 64'haaaa_aaaa_5555_5555)
        `CHK(adc_q_data_o, 10'h0)
        `CHK(posn_clk_o, 1'b1)
        rd_chk(REG_IN, 32'h0f0f_3cc3);
        // host and adc groups override the gpio drive
        wr(REG_SEL, 32'h7);
        @(posedge clock_i);
        hport_out_i <= {8'ha5, 8'h0f, 1'b1};
        #1;
        `CHK(pad2_ctl_o.oe, 32'hff00_200f)
        `CHK({pad2_ctl_o.out[13], pad2_ctl_o.out[7:0]}, 9'h1a5)
        `CHK(pad2_ctl_o.pull[31:0], 32'h5555_5555)
        `CHK(hport_in_o[12:5], {ext2[7:4], 4'h5})
        `CHK(hport_in_o[4:0], {ext2[9:8], ext2[10], ext2[11], ext2[12]})
        `CHK(adc_q_data_o, ext2[23:14])
        eo = 32'hff00_200f;
        rd_chk(REG_IN, (32'h0f00_20a5 & eo) | (ext2 & ~eo));
        @(posedge clock_i);
        hport_out_i.irq <= 1'b0;
        #1;
        `CHK(pad2_ctl_o.out[13], 1'b0)
        // released pads settle at their pulls
        wr(REG_SEL, 32'h4);
        wr(REG_DIR, 32'h0);
        en2 <= 32'h0;
        rd_chk(REG_IN, 32'h0000_ffff);
        en2 <= 32'hffff_ffff;
        // pad 24 clock out, lcd strobes, audio
        wr(REG_SEL, 32'h38);
        @(posedge clock_i);
        // peripheral values opposite to the gpio word, so a missed override shows
        {adc_clk_out_i, lcd_vsync_i, lcd_den_i, i2s_sdo_i, i2s_bclk_i} <= 5'b00011;
        i2s_bidir_out_i <= 2'b01;
        i2s_bidir_oe_i <= 2'b01;
        #1;
        `CHK(pad2_ctl_o.oe, 32'h7700_0000)
        `CHK(pad2_ctl_o.out[31:24] & 8'h77, 8'h70)
        `CHK(pad2_ctl_o.pull[63:48], 16'haaaa)
        `CHK({posn_clk_o, i2s_sdi_o, i2s_bidir_in_o}, {1'b0, ext2[27], ext2[31], 1'b1})
        // card port on the h pads, gpio drive suppressed
        wr(REG_SEL, 32'h1c0);
        @(posedge clock_i);
        {card0_command_line_out_i, card0_command_line_oe_i, card0_clk_out_i} <= 3'b111;
        card0_data_out_i <= 4'b1010;
        card0_data_oe_i <= 4'b0110;
        {gpioh_out_i, gpioh_oe_i} <= 16'hffff;
        #1;
        `CHK(padh_ctl_o.oe, 32'h2d)
        `CHK(padh_ctl_o.out[7:0] & 8'h2d, 8'h25)
        `CHK({card0_data_in_o, card0_command_line_in_o}, {exth[4], 2'b01, exth[1], 1'b1})
        `CHK({external_iq_marker_o, adc_clk_in_o}, {exth[6], exth[7]})
        `CHK(gpioh_in_o, padh_in_i)
        wr(REG_SEL, 32'h0);
        #1;
        `CHK(padh_ctl_o.oe, 32'hff)
        `CHK(pad2_ctl_o.oe, 32'h7000_0000)
        `CHK({external_iq_marker_o, adc_clk_in_o}, 2'b00)
        // every panel mode, plus one unused code
        foreach (modes[i]) begin
            wr(REG_SEL, {20'h0, modes[i], 9'h0});
            #1;
            `CHK(lcd_pins_o, lcd_exp(modes[i], lcd_bus_i))
        end
        tally_and_finish();
    end
endmodule : test_pfm_mux
